// ===== src/btos_pkg.sv
package btos_pkg;
   // Register addresses
   localparam logic [7:0] ADDR_FRAMER_CTRL_4 = 8'h00;
   localparam logic [7:0] ADDR_OVH_SRC_CTRL = 8'h01;
   localparam logic [7:0] ADDR_ALIGN_OVH = 8'h02;
   localparam logic [7:0] ADDR_NONALIGN_OVH = 8'h03;
   localparam logic [7:0] ADDR_SI_ALIGN = 8'h04;
   localparam logic [7:0] ADDR_SI_NONALIGN = 8'h05;
   localparam logic [7:0] ADDR_RAI = 8'h06;
   localparam logic [7:0] ADDR_SPARE_BASE = 8'h07;
   localparam logic [7:0] ADDR_SPARE_LAST = 8'h0B;
   localparam logic [7:0] ADDR_LINE_MODE = 8'h0C;
   localparam logic [7:0] ADDR_RX_LINE = 8'h0D;
   localparam logic [7:0] ADDR_TX_LINE = 8'h0E;
   localparam logic [7:0] ADDR_STATUS = 8'h0F;

   // Reset values
   localparam logic [7:0] RST_ALIGN_OVH = 8'h1B;
   localparam logic [7:0] RST_NONALIGN_OVH = 8'h40;
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_ONES = 8'hFF;

   // Line modes
   localparam logic [1:0] MODE_E1 = 2'h1;
   localparam logic [1:0] MODE_2048K = 2'h2;
   localparam logic [1:0] MODE_6312K = 2'h3;

   // Frame geometry
   localparam int FRAME_BITS = 256;
   localparam int MF_FRAMES = 16;
   localparam logic [7:0] LAST_BIT = 8'hFF;
   localparam logic [3:0] LAST_FRAME = 4'hF;
   localparam logic [2:0] SMF_LAST_FRAME = 3'h7;
   localparam logic [7:0] POS_SI = 8'h00;
   localparam logic [7:0] POS_NA_FIXED = 8'h01;
   localparam logic [7:0] POS_RAI = 8'h02;
   localparam logic [7:0] POS_SA4 = 8'h03;
   localparam logic [7:0] POS_OVH_LAST = 8'h07;
   // Multiframe alignment word and E bits, indexed by frame
   localparam logic [15:0] MFAW_BITS = 16'h0455;

   // CRC-4 polynomial taps, x^4 + x + 1
   localparam logic [3:0] CRC_TAPS = 4'h3;

   typedef struct packed {
      logic [4:0] reserved;
      logic passthrough;
      logic si_source_select;
      logic crc4_enable;
   } btos_framer_ctrl_s;

   typedef struct packed {
      logic [4:0] spare_en;
      logic rai_en;
      logic si_nonalign_en;
      logic si_align_en;
   } btos_ovh_src_ctrl_s;

   typedef struct packed {
      logic [3:0] reserved;
      logic [1:0] tx_mode;
      logic [1:0] rx_mode;
   } btos_line_mode_s;

   typedef struct packed {
      logic [1:0] reserved;
      logic [2:0] build_out;
      logic [2:0] impedance;
   } btos_tx_line_s;
endpackage : btos_pkg

// ===== src/btos_crc4.sv
`timescale 1ns/1ns
`default_nettype none
module btos_crc4 (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic srst_in,
   // Bit stream
   input wire logic bit_tick_in,
   input wire logic bit_in,
   input wire logic bit_is_crc_in,
   input wire logic block_end_in,
   // Remainder of last block
   output logic [3:0] crc_out
);
   logic [3:0] shift;
   logic [3:0] next_shift;
   logic fb;

   // C bit slots enter as zero
   always_comb begin
      fb = (bit_in & ~bit_is_crc_in) ^ shift[3];
      next_shift = {shift[2:0], 1'b0} ^ (fb ? btos_pkg::CRC_TAPS : 4'h0);
   end

   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         shift <= 4'h0;
         crc_out <= 4'h0;
      end else if (bit_tick_in) begin
         if (block_end_in) begin
            shift <= 4'h0;
            crc_out <= next_shift;
         end else begin
            shift <= next_shift;
         end
      end
   end
endmodule : btos_crc4
`default_nettype wire

// ===== src/btos_overhead_source.sv
// Notes on behaviour
// - FAS from serial under pass-through, else register
// - Align Si register wins when enabled
// - Else CRC-4 mode fills Si bits
// - Else Si select zero takes serial
// - Select one: serial if pass-through, else register
// - Non-align Si register first, then chain
// - Sa bits: register, serial, non-align register
// - Receive mode 10 selects 2048kHz
// - Transmit mode 10 selects 2048kHz
// - 2048kHz output is unframed all ones
// - Receive mode 11 selects 6312kHz
// - No 6312kHz transmit output
// - Frame registers sampled at align start
// - Per-bit registers sampled at multiframe start
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
module btos_overhead_source (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic srst_in,
   // Register port
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [7:0] reg_rdata_out,
   // Serial payload
   input wire logic tx_bit_tick_in,
   input wire logic tx_serial_in,
   // Line side
   output logic tx_line_bit_out,
   output logic tx_line_valid_out,
   // Mode and line settings
   output logic rx_mode_2048_out,
   output logic rx_mode_6312_out,
   output logic tx_mode_2048_out,
   output logic [2:0] rx_impedance_select_out,
   output logic [2:0] tx_impedance_select_out,
   output logic [2:0] tx_build_out_select_out,
   // Status
   output logic tx_align_frame_flag_out,
   output logic tx_multiframe_flag_out
);
   btos_pkg::btos_framer_ctrl_s tx_framer_ctrl_4;
   btos_pkg::btos_ovh_src_ctrl_s tx_overhead_source_ctrl;
   btos_pkg::btos_line_mode_s line_mode_ctrl;
   btos_pkg::btos_tx_line_s tx_line_ctrl;
   logic [7:0] rx_line_ctrl;
   logic [7:0] tx_align_frame_overhead;
   logic [7:0] tx_nonalign_frame_overhead;
   logic [7:0] tx_si_align_reg;
   logic [7:0] tx_si_nonalign_reg;
   logic [7:0] tx_rai_reg;
   logic [7:0] tx_spare_bit_reg [5];
   logic [7:0] sh_align;
   logic [7:0] sh_nonalign;
   logic [7:0] sh_si_align;
   logic [7:0] sh_si_nonalign;
   logic [7:0] sh_rai;
   logic [7:0] sh_spare [5];
   logic [7:0] bit_idx;
   logic [3:0] frame_idx;
   logic tx_align_frame_flag;
   logic tx_multiframe_flag;
   logic [3:0] crc_val;
   logic next_bit;
   logic is_align;
   logic is_ovh;
   logic df_end;
   logic mf_end;
   logic smf_end;
   logic [2:0] pair_idx;
   logic status_rd;

   function automatic logic pick(input logic [7:0] val, input logic [2:0] idx);
      pick = val[3'h7 - idx];
   endfunction : pick

   assign is_align = ~frame_idx[0];
   assign is_ovh = bit_idx <= btos_pkg::POS_OVH_LAST;
   assign pair_idx = frame_idx[3:1];
   assign df_end = tx_bit_tick_in && bit_idx == btos_pkg::LAST_BIT && frame_idx[0];
   assign mf_end = df_end && frame_idx == btos_pkg::LAST_FRAME;
   assign smf_end = tx_bit_tick_in && bit_idx == btos_pkg::LAST_BIT
      && frame_idx[2:0] == btos_pkg::SMF_LAST_FRAME;
   assign status_rd = reg_rd_in && reg_addr_in == btos_pkg::ADDR_STATUS;

   // Software writes
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         tx_framer_ctrl_4 <= '0;
         tx_overhead_source_ctrl <= '0;
         line_mode_ctrl <= '0;
         tx_line_ctrl <= '0;
         rx_line_ctrl <= btos_pkg::RST_ZERO;
         tx_align_frame_overhead <= btos_pkg::RST_ALIGN_OVH;
         tx_nonalign_frame_overhead <= btos_pkg::RST_NONALIGN_OVH;
         tx_si_align_reg <= btos_pkg::RST_ONES;
         tx_si_nonalign_reg <= btos_pkg::RST_ONES;
         tx_rai_reg <= btos_pkg::RST_ZERO;
         for (int i = 0; i < 5; i++) begin
            tx_spare_bit_reg[i] <= btos_pkg::RST_ONES;
         end
      end else if (reg_wr_in) begin
         case (reg_addr_in)
            btos_pkg::ADDR_FRAMER_CTRL_4: tx_framer_ctrl_4 <= {5'h00, reg_wdata_in[2:0]};
            btos_pkg::ADDR_OVH_SRC_CTRL: tx_overhead_source_ctrl <= reg_wdata_in;
            btos_pkg::ADDR_ALIGN_OVH: tx_align_frame_overhead <= reg_wdata_in;
            btos_pkg::ADDR_NONALIGN_OVH: tx_nonalign_frame_overhead <= reg_wdata_in;
            btos_pkg::ADDR_SI_ALIGN: tx_si_align_reg <= reg_wdata_in;
            btos_pkg::ADDR_SI_NONALIGN: tx_si_nonalign_reg <= reg_wdata_in;
            btos_pkg::ADDR_RAI: tx_rai_reg <= reg_wdata_in;
            btos_pkg::ADDR_LINE_MODE: line_mode_ctrl <= {4'h0, reg_wdata_in[3:0]};
            btos_pkg::ADDR_RX_LINE: rx_line_ctrl <= {5'h00, reg_wdata_in[2:0]};
            btos_pkg::ADDR_TX_LINE: tx_line_ctrl <= {2'h0, reg_wdata_in[5:0]};
            default: begin
               if (reg_addr_in >= btos_pkg::ADDR_SPARE_BASE
                     && reg_addr_in <= btos_pkg::ADDR_SPARE_LAST) begin
                  tx_spare_bit_reg[3'(reg_addr_in - btos_pkg::ADDR_SPARE_BASE)] <= reg_wdata_in;
               end
            end
         endcase
      end
   end

   // Read data, one cycle later
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         reg_rdata_out <= 8'h00;
      end else if (reg_rd_in) begin
         case (reg_addr_in)
            btos_pkg::ADDR_FRAMER_CTRL_4: reg_rdata_out <= tx_framer_ctrl_4;
            btos_pkg::ADDR_OVH_SRC_CTRL: reg_rdata_out <= tx_overhead_source_ctrl;
            btos_pkg::ADDR_ALIGN_OVH: reg_rdata_out <= tx_align_frame_overhead;
            btos_pkg::ADDR_NONALIGN_OVH: reg_rdata_out <= tx_nonalign_frame_overhead;
            btos_pkg::ADDR_SI_ALIGN: reg_rdata_out <= tx_si_align_reg;
            btos_pkg::ADDR_SI_NONALIGN: reg_rdata_out <= tx_si_nonalign_reg;
            btos_pkg::ADDR_RAI: reg_rdata_out <= tx_rai_reg;
            btos_pkg::ADDR_LINE_MODE: reg_rdata_out <= line_mode_ctrl;
            btos_pkg::ADDR_RX_LINE: reg_rdata_out <= rx_line_ctrl;
            btos_pkg::ADDR_TX_LINE: reg_rdata_out <= tx_line_ctrl;
            btos_pkg::ADDR_STATUS: reg_rdata_out <= {6'h00, tx_multiframe_flag,
               tx_align_frame_flag};
            default: begin
               if (reg_addr_in >= btos_pkg::ADDR_SPARE_BASE
                     && reg_addr_in <= btos_pkg::ADDR_SPARE_LAST) begin
                  reg_rdata_out <= tx_spare_bit_reg[3'(reg_addr_in - btos_pkg::ADDR_SPARE_BASE)];
               end else begin
                  reg_rdata_out <= 8'h00;
               end
            end
         endcase
      end
   end

   // Bit and frame position
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         bit_idx <= 8'h00;
         frame_idx <= 4'h0;
      end else if (tx_bit_tick_in) begin
         bit_idx <= bit_idx + 8'h01;
         if (bit_idx == btos_pkg::LAST_BIT) begin
            frame_idx <= frame_idx + 4'h1;
         end
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         sh_align <= btos_pkg::RST_ALIGN_OVH;
         sh_nonalign <= btos_pkg::RST_NONALIGN_OVH;
      end else if (df_end) begin
         sh_align <= tx_align_frame_overhead;
         sh_nonalign <= tx_nonalign_frame_overhead;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         sh_si_align <= btos_pkg::RST_ONES;
         sh_si_nonalign <= btos_pkg::RST_ONES;
         sh_rai <= btos_pkg::RST_ZERO;
         for (int i = 0; i < 5; i++) begin
            sh_spare[i] <= btos_pkg::RST_ONES;
         end
      end else if (mf_end) begin
         sh_si_align <= tx_si_align_reg;
         sh_si_nonalign <= tx_si_nonalign_reg;
         sh_rai <= tx_rai_reg;
         for (int i = 0; i < 5; i++) begin
            sh_spare[i] <= tx_spare_bit_reg[i];
         end
      end
   end

   // Sticky flags, set wins over read clear
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         tx_align_frame_flag <= 1'b0;
         tx_multiframe_flag <= 1'b0;
      end else begin
         tx_align_frame_flag <= df_end | (tx_align_frame_flag & ~status_rd);
         tx_multiframe_flag <= mf_end | (tx_multiframe_flag & ~status_rd);
      end
   end

   btos_crc4 u_crc4 (
      .ref_clk_in(ref_clk_in),
      .srst_in(srst_in),
      .bit_tick_in(tx_bit_tick_in),
      .bit_in(next_bit),
      .bit_is_crc_in(is_align && bit_idx == btos_pkg::POS_SI),
      .block_end_in(smf_end),
      .crc_out(crc_val)
   );

   always_comb begin
      next_bit = tx_serial_in;
      if (is_ovh) begin
         if (bit_idx == btos_pkg::POS_SI) begin
            if (is_align && tx_overhead_source_ctrl.si_align_en) begin
               next_bit = pick(sh_si_align, pair_idx);
            end else if (!is_align && tx_overhead_source_ctrl.si_nonalign_en) begin
               next_bit = pick(sh_si_nonalign, pair_idx);
            end else if (tx_framer_ctrl_4.crc4_enable) begin
               next_bit = is_align ? crc_val[2'h3 - frame_idx[2:1]] : mfaw_bit(frame_idx);
            end else if (!tx_framer_ctrl_4.si_source_select) begin
               next_bit = tx_serial_in;
            end else if (tx_framer_ctrl_4.passthrough) begin
               next_bit = tx_serial_in;
            end else begin
               next_bit = is_align ? sh_align[7] : sh_nonalign[7];
            end
         end else if (is_align || bit_idx == btos_pkg::POS_NA_FIXED) begin
            next_bit = tx_framer_ctrl_4.passthrough ? tx_serial_in
               : pick(is_align ? sh_align : sh_nonalign, bit_idx[2:0]);
         end else if (bit_idx == btos_pkg::POS_RAI && tx_overhead_source_ctrl.rai_en) begin
            next_bit = pick(sh_rai, pair_idx);
         end else if (bit_idx >= btos_pkg::POS_SA4
               && tx_overhead_source_ctrl.spare_en[3'(bit_idx - btos_pkg::POS_SA4)]) begin
            next_bit = pick(sh_spare[3'(bit_idx - btos_pkg::POS_SA4)], pair_idx);
         end else begin
            next_bit = tx_framer_ctrl_4.passthrough ? tx_serial_in
               : pick(sh_nonalign, bit_idx[2:0]);
         end
      end
   end

   function automatic logic mfaw_bit(input logic [3:0] f);
      mfaw_bit = btos_pkg::MFAW_BITS[4'hF - f];
   endfunction : mfaw_bit

   // Line output
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         tx_line_bit_out <= 1'b0;
         tx_line_valid_out <= 1'b0;
      end else begin
         tx_line_valid_out <= 1'b0;
         if (tx_bit_tick_in) begin
            case (line_mode_ctrl.tx_mode)
               btos_pkg::MODE_E1: begin
                  tx_line_bit_out <= next_bit;
                  tx_line_valid_out <= 1'b1;
               end
               btos_pkg::MODE_2048K: begin
                  tx_line_bit_out <= 1'b1;
                  tx_line_valid_out <= 1'b1;
               end
               default: tx_line_bit_out <= 1'b0;
            endcase
         end
      end
   end

   assign rx_mode_2048_out = line_mode_ctrl.rx_mode == btos_pkg::MODE_2048K;
   assign rx_mode_6312_out = line_mode_ctrl.rx_mode == btos_pkg::MODE_6312K;
   assign tx_mode_2048_out = line_mode_ctrl.tx_mode == btos_pkg::MODE_2048K;
   assign rx_impedance_select_out = rx_line_ctrl[2:0];
   assign tx_impedance_select_out = tx_line_ctrl.impedance;
   assign tx_build_out_select_out = tx_line_ctrl.build_out;
   assign tx_align_frame_flag_out = tx_align_frame_flag;
   assign tx_multiframe_flag_out = tx_multiframe_flag;

   sequence s_e1_tick;
      tx_bit_tick_in && line_mode_ctrl.tx_mode == btos_pkg::MODE_E1;
   endsequence

   sequence s_fas_slot;
      s_e1_tick ##0 is_align && bit_idx != btos_pkg::POS_SI && is_ovh;
   endsequence

   a_fas_passthrough: assert property (@(posedge ref_clk_in) disable iff (srst_in)
      s_fas_slot ##0 tx_framer_ctrl_4.passthrough |=> tx_line_bit_out == $past(tx_serial_in))
      else $error("FAS bit not from serial input");

   a_fas_register: assert property (@(posedge ref_clk_in) disable iff (srst_in)
      s_fas_slot ##0 !tx_framer_ctrl_4.passthrough
      |=> tx_line_bit_out == $past(sh_align[3'h7 - bit_idx[2:0]]))
      else $error("FAS bit not from align register");

   a_si_align_reg: assert property (@(posedge ref_clk_in) disable iff (srst_in)
      s_e1_tick ##0 is_align && bit_idx == btos_pkg::POS_SI
      && tx_overhead_source_ctrl.si_align_en
      |=> tx_line_bit_out == $past(sh_si_align[3'h7 - pair_idx]))
      else $error("Align Si not from its register");

   a_si_serial: assert property (@(posedge ref_clk_in) disable iff (srst_in)
      s_e1_tick ##0 bit_idx == btos_pkg::POS_SI && !tx_overhead_source_ctrl.si_align_en
      && !tx_overhead_source_ctrl.si_nonalign_en && !tx_framer_ctrl_4.crc4_enable
      && !tx_framer_ctrl_4.si_source_select |=> tx_line_bit_out == $past(tx_serial_in))
      else $error("Si bit not from serial input");

   a_si_mfaw: assert property (@(posedge ref_clk_in) disable iff (srst_in)
      s_e1_tick ##0 !is_align && bit_idx == btos_pkg::POS_SI && frame_idx == 4'h5
      && !tx_overhead_source_ctrl.si_nonalign_en && tx_framer_ctrl_4.crc4_enable
      |=> tx_line_bit_out)
      else $error("Multiframe word bit wrong");

   a_mode_ones: assert property (@(posedge ref_clk_in) disable iff (srst_in)
      tx_bit_tick_in && line_mode_ctrl.tx_mode == btos_pkg::MODE_2048K
      |=> tx_line_valid_out && tx_line_bit_out)
      else $error("2048kHz output not all ones");

   a_no_6312_tx: assert property (@(posedge ref_clk_in) disable iff (srst_in)
      line_mode_ctrl.tx_mode == btos_pkg::MODE_6312K |=> !tx_line_valid_out)
      else $error("6312kHz transmit produced output");

   a_af_flag: assert property (@(posedge ref_clk_in) disable iff (srst_in)
      df_end |=> tx_align_frame_flag && sh_align == $past(tx_align_frame_overhead))
      else $error("Align sample or flag missing");

   a_mf_flag: assert property (@(posedge ref_clk_in) disable iff (srst_in)
      mf_end |=> tx_multiframe_flag && sh_rai == $past(tx_rai_reg))
      else $error("Multiframe sample or flag missing");
endmodule : btos_overhead_source
`default_nettype wire

// ===== bench/btos_serial_src.sv
`timescale 1ns/1ns
`default_nettype none
module btos_serial_src (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic srst_in,
   // Control from bench
   input wire logic run_in,
   input wire logic [1:0] gap_in,
   input wire logic ser_val_in,
   // Toward the framer
   output logic tick_out,
   output logic serial_out,
   // Position of the tick now shown, and of the one before
   output logic [11:0] tick_pos_out,
   output logic [11:0] pos_out
);
   logic [11:0] cnt;
   logic [1:0] wait_cnt;

   // Serial bit only meaningful with a tick; toggles otherwise
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         tick_out <= 1'b0;
         serial_out <= 1'b0;
         cnt <= 12'h000;
         wait_cnt <= 2'h0;
         tick_pos_out <= 12'h000;
         pos_out <= 12'h000;
      end else begin
         if (tick_out) begin
            pos_out <= tick_pos_out;
         end
         if (run_in && wait_cnt == 2'h0) begin
            tick_out <= 1'b1;
            serial_out <= ser_val_in;
            tick_pos_out <= cnt;
            cnt <= cnt + 12'h001;
            wait_cnt <= gap_in;
         end else begin
            tick_out <= 1'b0;
            serial_out <= ~serial_out;
            if (wait_cnt != 2'h0) begin
               wait_cnt <= wait_cnt - 2'h1;
            end
         end
      end
   end
endmodule : btos_serial_src
`default_nettype wire

// ===== bench/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr_s = 1'b0;
   logic rd_s = 1'b0;
   logic [7:0] rdata;
   logic tick, ser, lbit, lval, rx2048, rx6312, tx2048, af_flag, mf_flag;
   logic [2:0] rx_imp, tx_imp, bo;
   logic run = 1'b0;
   logic [1:0] gap = 2'h0;
   logic ser_val = 1'b0;
   logic [11:0] tick_pos, pos_d;
   logic [127:0] cap;
   logic [31:0] cfg;
   logic [7:0] pb [0:7] = '{8'hA5, 8'h3C, 8'h96, 8'h0F, 8'hE1, 8'h5A, 8'hC3, 8'h78};
   logic [31:0] cfgs [0:5] = '{32'h0200_1B40, 32'h8600_1B40, 32'h8000_6EB3,
      32'h0300_6EB3, 32'h05FF_6EB3, 32'h82A4_912D};
   // Nonalign Si in CRC-4 mode: 001011 then E bits, by frame
   logic [15:0] mfaw = 16'hAA20;
   int error_cnt = 0;
   int comparisons = 0;
   int vcnt = 0;
   int ones = 0;

   always #25 clk = ~clk;

   btos_overhead_source i_dut (.ref_clk_in(clk), .srst_in(srst), .reg_addr_in(addr),
      .reg_wdata_in(wdata), .reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_rdata_out(rdata),
      .tx_bit_tick_in(tick), .tx_serial_in(ser), .tx_line_bit_out(lbit),
      .tx_line_valid_out(lval), .rx_mode_2048_out(rx2048), .rx_mode_6312_out(rx6312),
      .tx_mode_2048_out(tx2048), .rx_impedance_select_out(rx_imp),
      .tx_impedance_select_out(tx_imp), .tx_build_out_select_out(bo),
      .tx_align_frame_flag_out(af_flag), .tx_multiframe_flag_out(mf_flag));

   btos_serial_src i_src (.ref_clk_in(clk), .srst_in(srst), .run_in(run), .gap_in(gap),
      .ser_val_in(ser_val), .tick_out(tick), .serial_out(ser), .tick_pos_out(tick_pos),
      .pos_out(pos_d));

   // Overhead bits of each frame kept by frame and position
   always @(posedge clk) begin
      if (lval === 1'b1) begin
         vcnt++;
         if (lbit === 1'b1) ones++;
         if (pos_d[7:3] == 5'h00) cap[{pos_d[11:8], pos_d[2:0]}] = lbit;
      end
   end

   task chk(input logic [7:0] seen, input logic [7:0] exp, input string nm);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask : wr

   task rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      #1;
      chk(rdata, exp, $sformatf("reg_%h", a));
   endtask : rd

   task wait_mf;
      for (int i = 0; i < 20000; i++) begin
         @(posedge clk);
         if (tick === 1'b1 && tick_pos === 12'h000) return;
      end
      // A stalled source counts as a failure
      error_cnt++;
   endtask : wait_mf

   // Priority chain per overhead bit; bit 1 marks a defined value
   function automatic logic [1:0] exp_ovh(input int f, input int k);
      logic s;
      logic [2:0] n;
      n = 3'(7 - f / 2);
      s = cfg[26] ? cfg[31] : (f % 2 == 1 ? cfg[7 - k] : cfg[15 - k]);
      if (f % 2 == 0) begin
         if (k != 0) return {1'b1, s};
         if (cfg[16]) return {1'b1, pb[0][n]};
         if (cfg[24]) return 2'b00;
         return {1'b1, cfg[25] ? s : cfg[31]};
      end
      if (k == 0) begin
         if (cfg[17]) return {1'b1, pb[1][n]};
         if (cfg[24]) return {1'b1, mfaw[f]};
         return {1'b1, cfg[25] ? s : cfg[31]};
      end
      if (k >= 2 && cfg[16 + k]) return {1'b1, pb[k][n]};
      return {1'b1, s};
   endfunction : exp_ovh

   // Source selection over one whole multiframe
   task run_cfg(input logic [31:0] c, input logic [1:0] g);
      logic [1:0] e;
      cfg = c;
      ser_val <= c[31];
      wr(btos_pkg::ADDR_FRAMER_CTRL_4, {5'h00, c[26:24]});
      wr(btos_pkg::ADDR_OVH_SRC_CTRL, c[23:16]);
      wr(btos_pkg::ADDR_ALIGN_OVH, c[15:8]);
      wr(btos_pkg::ADDR_NONALIGN_OVH, c[7:0]);
      gap <= g;
      run <= 1'b1;
      wait_mf();
      cap = 'x;
      wait_mf();
      run <= 1'b0;
      for (int f = 0; f < 16; f++) begin
         for (int k = 0; k < 8; k++) begin
            e = exp_ovh(f, k);
            if (e[1]) chk({7'h00, cap[f * 8 + k]}, {7'h00, e[0]}, $sformatf("ovh_f%0d_b%0d", f, k));
         end
      end
   endtask : run_cfg

   task end_sim;
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : end_sim

   // Budget well above the longest expected run
   initial begin
      #5_000_000;
      error_cnt++;
      end_sim();
   end

   initial begin
      repeat (16) @(posedge clk);
      srst <= 1'b0;
      rd(8'h02, 8'h1B);
      rd(8'h03, 8'h40);
      rd(8'h04, 8'hFF);
      rd(8'h0B, 8'hFF);
      rd(8'h06, 8'h00);
      // Status is read only, unmapped reads zero
      wr(8'h0F, 8'hFF);
      rd(8'h0F, 8'h00);
      rd(8'h3A, 8'h00);
      wr(8'h0D, 8'h03);
      wr(8'h0E, 8'h0B);
      rd(8'h0E, 8'h0B);
      // line interface writes land in this block's RX and TX line registers, seen on the select outputs
      chk({2'h0, rx_imp, tx_imp}, 8'h1B, "impedance");
      chk({5'h00, bo}, 8'h01, "build_out");
      for (int m = 0; m < 16; m++) begin
         wr(8'h0C, 8'(m));
         #1;
         chk({5'h00, rx2048, rx6312, tx2048}, {5'h00, m[1:0] == 2'h2, m[1:0] == 2'h3, m[3:2] == 2'h2}, "mode_decode");
      end
      wr(8'h0C, 8'h05);
      for (int i = 0; i < 8; i++) wr(8'h04 + 8'(i), pb[i]);
      for (int i = 0; i < 6; i++) run_cfg(cfgs[i], (i == 3) ? 2'h1 : 2'h0);
      chk({6'h00, mf_flag, af_flag}, 8'h03, "flag_pins");
      rd(btos_pkg::ADDR_STATUS, 8'h03);
      rd(btos_pkg::ADDR_STATUS, 8'h00);
      // Line output per transmit mode, last as counts may drift
      for (int t = 0; t < 4; t++) begin
         wr(8'h0C, {4'h0, 2'(t), 2'h1});
         vcnt = 0;
         ones = 0;
         run <= 1'b1;
         repeat (20) @(posedge clk);
         run <= 1'b0;
         repeat (3) @(posedge clk);
         chk(8'(vcnt), (t == 1 || t == 2) ? 8'd20 : 8'd0, "valid_count");
         if (t == 2) chk(8'(ones), 8'd20, "ones_2048");
      end
      end_sim();
   end
endmodule : tb_top
`default_nettype wire
